// ### core/cwp_guard.sv
// configuration word store, decode and program memory protection gate
module cwp_guard #(
    parameter logic [11:0] MEM_TOP = 12'h1FF,
    parameter bit HAS_CAL = 1'b1
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic mode_entry_i,
    input wire logic addr_inc_i,
    input wire logic rd_req_i,
    input wire logic prog_req_i,
    input wire logic [cwp_pkg::WORD_W-1:0] prog_data_i,
    input wire logic [cwp_pkg::WORD_W-1:0] mem_rd_data_i,
    output logic [cwp_pkg::ADDR_W-1:0] addr_o,
    output logic [cwp_pkg::WORD_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic mem_wr_o,
    output logic [cwp_pkg::WORD_W-1:0] mem_wr_data_o,
    output logic prog_blocked_o,
    output logic [cwp_pkg::WORD_W-1:0] config_word_o,
    output logic reset_pin_enable_o,
    output logic code_protect_o,
    output logic watchdog_enable_o,
    output logic [3:0] osc_select_o
);
    import cwp_pkg::*;

    // address group
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic at_cfg_q;
    logic at_cfg_d;

    // read group
    logic [WORD_W-1:0] rdat_q;
    logic [WORD_W-1:0] rdat_d;
    logic rvld_q;
    logic rvld_d;

    // program group
    logic wr_q;
    logic wr_d;
    logic [WORD_W-1:0] wdat_q;
    logic [WORD_W-1:0] wdat_d;
    logic blk_q;
    logic blk_d;

    // config group
    logic [WORD_W-1:0] cfg_q;
    logic [WORD_W-1:0] cfg_d;

    // decode group
    logic rst_pin_q;
    logic rst_pin_d;
    logic cp_q;
    logic cp_d;
    logic wdt_q;
    logic wdt_d;
    cwp_osc_e osc_q;
    cwp_osc_e osc_d;

    // request qualifiers shared by the groups
    logic take_entry;
    logic take_inc;
    logic take_rd;
    logic take_prog;
    logic cfg_sel;
    logic in_prot;
    logic gated;
    logic at_wrap;
    logic [ADDR_W-1:0] cal_addr;
    logic [ADDR_W-1:0] id_last;

    // one request is taken per edge; lower priorities drop silently
    always_comb begin
        take_entry = mode_entry_i;
        take_inc = !mode_entry_i && addr_inc_i;
        take_rd = !mode_entry_i && !addr_inc_i && rd_req_i;
        take_prog = !mode_entry_i && !addr_inc_i && !rd_req_i && prog_req_i;
    end

    always_comb begin
        cal_addr = MEM_TOP;
        // ids sit just above the top word; the last one wraps the counter
        id_last = ADDR_W'(MEM_TOP + ID_COUNT);
        at_wrap = addr_q >= id_last;
        cfg_sel = at_cfg_q;
        in_prot = !cfg_sel && (addr_q >= PROT_LOW) && (addr_q <= MEM_TOP);
        if (HAS_CAL && (addr_q == cal_addr)) begin
            in_prot = 1'b0;
        end
        gated = in_prot && !cfg_q[BIT_CP_N];
    end

    // address counter
    always_comb begin
        addr_d = addr_q;
        at_cfg_d = at_cfg_q;
        if (take_entry) begin
            addr_d = CFG_ADDR;
            at_cfg_d = 1'b1;
        end else if (take_inc) begin
            at_cfg_d = 1'b0;
            if (at_cfg_q || at_wrap) begin
                addr_d = WORD_ZERO;
            end else begin
                addr_d = ADDR_W'(addr_q + ADDR_ONE);
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_q <= CFG_ADDR;
            at_cfg_q <= 1'b1;
        end else if (clk_en_i) begin
            addr_q <= addr_d;
            at_cfg_q <= at_cfg_d;
        end
    end

    // read data
    always_comb begin
        rdat_d = rdat_q;
        if (take_rd) begin
            if (cfg_sel) begin
                rdat_d = cfg_q;
            end else if (gated) begin
                rdat_d = WORD_ZERO;
            end else begin
                rdat_d = mem_rd_data_i;
            end
        end
    end

    // held until the next read so a slow programmer can still shift it out
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdat_q <= WORD_ZERO;
        end else if (clk_en_i) begin
            rdat_q <= rdat_d;
        end
    end

    // read strobe
    always_comb begin
        rvld_d = take_rd;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rvld_q <= 1'b0;
        end else if (clk_en_i) begin
            rvld_q <= rvld_d;
        end
    end

    // write strobe and data towards the array
    always_comb begin
        wr_d = 1'b0;
        wdat_d = wdat_q;
        if (take_prog && !cfg_sel && !gated) begin
            wr_d = 1'b1;
            wdat_d = prog_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q <= 1'b0;
            wdat_q <= WORD_ZERO;
        end else if (clk_en_i) begin
            wr_q <= wr_d;
            wdat_q <= wdat_d;
        end
    end

    // blocked strobe
    always_comb begin
        blk_d = take_prog && !cfg_sel && gated;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            blk_q <= 1'b0;
        end else if (clk_en_i) begin
            blk_q <= blk_d;
        end
    end

    // config word
    always_comb begin
        cfg_d = cfg_q;
        if (take_prog && cfg_sel) begin
            // otp cells only clear, so programming ands in the new word
            cfg_d = cfg_q & prog_data_i;
        end
    end

    // erased array holds ones, so reset is a stand-in for a blank part
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q <= CFG_ERASED;
        end else if (clk_en_i) begin
            cfg_q <= cfg_d;
        end
    end

    // decoded fields lag the stored word by one cycle to keep outputs registered
    always_comb begin
        rst_pin_d = cfg_q[BIT_RST_PIN];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_pin_q <= 1'b1;
        end else if (clk_en_i) begin
            rst_pin_q <= rst_pin_d;
        end
    end

    always_comb begin
        cp_d = !cfg_q[BIT_CP_N];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cp_q <= 1'b0;
        end else if (clk_en_i) begin
            cp_q <= cp_d;
        end
    end

    always_comb begin
        wdt_d = cfg_q[BIT_WDT];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdt_q <= 1'b1;
        end else if (clk_en_i) begin
            wdt_q <= wdt_d;
        end
    end

    always_comb begin
        case ({cfg_q[OSC_HI], cfg_q[OSC_LO]})
            OSC_EXT_RC: osc_d = CWP_EXT_RC;
            OSC_INT_RC: osc_d = CWP_INT_RC;
            OSC_XTAL: osc_d = CWP_XTAL;
            default: osc_d = CWP_LOWPWR;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_q <= CWP_EXT_RC;
        end else if (clk_en_i) begin
            osc_q <= osc_d;
        end
    end

    assign addr_o = addr_q;
    assign rd_data_o = rdat_q;
    assign rd_valid_o = rvld_q;
    assign mem_wr_o = wr_q;
    assign mem_wr_data_o = wdat_q;
    assign prog_blocked_o = blk_q;
    assign config_word_o = cfg_q;
    assign reset_pin_enable_o = rst_pin_q;
    assign code_protect_o = cp_q;
    assign watchdog_enable_o = wdt_q;
    assign osc_select_o = osc_q;
endmodule

// ### core/cwp_pkg.sv
// constants for configuration word decode and code protection gating
package cwp_pkg;
    localparam int ADDR_W = 12;
    localparam int WORD_W = 12;
    localparam logic [11:0] CFG_ADDR = 12'hFFF;
    localparam logic [11:0] CFG_ERASED = 12'hFFF;
    localparam logic [11:0] OPEN_TOP = 12'h03F;
    localparam logic [11:0] PROT_LOW = 12'h040;
    localparam logic [11:0] ID_COUNT = 12'h004;
    localparam logic [11:0] ADDR_ONE = 12'h001;
    localparam logic [11:0] WORD_ZERO = 12'h000;
    localparam int BIT_RST_PIN = 4;
    localparam int BIT_CP_N = 3;
    localparam int BIT_WDT = 2;
    localparam int OSC_HI = 1;
    localparam int OSC_LO = 0;
    localparam logic [1:0] OSC_EXT_RC = 2'h3;
    localparam logic [1:0] OSC_INT_RC = 2'h2;
    localparam logic [1:0] OSC_XTAL = 2'h1;
    localparam logic [1:0] OSC_LOWPWR = 2'h0;
    typedef enum logic [3:0] {
        CWP_EXT_RC = 4'h1,
        CWP_INT_RC = 4'h2,
        CWP_XTAL = 4'h4,
        CWP_LOWPWR = 4'h8
    } cwp_osc_e;
endpackage

// ### testbench/cwp_mem_model.sv
// program memory array behind the guard
module cwp_mem_model (
    input wire logic clock_i,
    input wire logic wr_i,
    input wire logic [11:0] addr_i,
    input wire logic [11:0] wdata_i,
    output logic [11:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] mem_q [4096];
    initial foreach (mem_q[i]) mem_q[i] = 12'hFFF;
    assign rdata_o = mem_q[addr_i];
    always @(posedge clock_i) if (wr_i) mem_q[addr_i] <= wdata_i;
endmodule

// ### testbench/cwp_guard_checker.sv
// guard port assertions
module cwp_guard_checker #(parameter logic [11:0] MEM_TOP = 12'h1FF, parameter bit HAS_CAL = 1) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic mode_entry_i,
    input wire logic addr_inc_i,
    input wire logic rd_req_i,
    input wire logic prog_req_i,
    input wire logic rd_valid_o,
    input wire logic mem_wr_o,
    input wire logic prog_blocked_o,
    input wire logic reset_pin_enable_o,
    input wire logic code_protect_o,
    input wire logic watchdog_enable_o,
    input wire logic [3:0] osc_select_o,
    input wire logic [11:0] prog_data_i,
    input wire logic [11:0] mem_rd_data_i,
    input wire logic [11:0] addr_o,
    input wire logic [11:0] rd_data_o,
    input wire logic [11:0] mem_wr_data_o,
    input wire logic [11:0] config_word_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import cwp_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    wire g = clk_en_i && !mode_entry_i && !addr_inc_i;
    wire r = g && rd_req_i;
    wire p = g && !rd_req_i && prog_req_i;
    wire c = addr_o == CFG_ADDR;
    wire z = !config_word_o[BIT_CP_N] && addr_o >= PROT_LOW && addr_o <= MEM_TOP
        && !(HAS_CAL && addr_o == MEM_TOP);
    rd_gate_a:
        assert property (r && z |=> rd_valid_o && !rd_data_o) else $error("gated read");
    rd_open_a:
        assert property (r && !z && !c |=> rd_data_o == $past(mem_rd_data_i)) else $error("rd");
    wr_block_a:
        assert property (p && z |=> prog_blocked_o && !mem_wr_o) else $error("gated wr");
    wr_open_a:
        assert property (p && !z && !c |=> mem_wr_o && mem_wr_data_o == $past(prog_data_i))
            else $error("wr");
    cfg_and_a:
        assert property (p && c |=> config_word_o == ($past(config_word_o) & $past(prog_data_i)))
            else $error("cfg");
    inc_wrap_a:
        assert property (clk_en_i && !mode_entry_i && addr_inc_i && c |=> addr_o == 0)
            else $error("wrap");
    dec_bit_a:
        assert property (clk_en_i |=> {reset_pin_enable_o, code_protect_o, watchdog_enable_o}
            == $past({config_word_o[4], !config_word_o[3], config_word_o[2]})) else $error("dec");
    osc_sel_a:
        assert property (clk_en_i |=> osc_select_o == 4'h8 >> $past(config_word_o[1:0]))
            else $error("osc");
    cover property (r && z);
    cover property (p && z);
    cover property (p && c);
endmodule
bind cwp_guard cwp_guard_checker #(.MEM_TOP(MEM_TOP), .HAS_CAL(HAS_CAL)) chk (.*);

// ### testbench/cwp_guard_tb.sv
// guard bench
module cwp_guard_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cwp_pkg::*;
    logic clock_i = 0, sys_rst_i = 1, clk_en_i = 1, mode_entry_i = 0, addr_inc_i = 0;
    logic rd_req_i = 0, prog_req_i = 0, rd_valid_o, mem_wr_o, prog_blocked_o;
    logic reset_pin_enable_o, code_protect_o, watchdog_enable_o;
    logic [3:0] osc_select_o;
    logic [11:0] prog_data_i = 0, mem_rd_data_i, addr_o, rd_data_o, mem_wr_data_o, config_word_o;
    logic [11:0] ad [5] = '{12'h000, 12'h03F, 12'h040, 12'h1FF, 12'h203};
    int miscompares = 0, checks_done = 0;
    cwp_guard dut (.*);
    cwp_mem_model mem (.clock_i, .wr_i(mem_wr_o), .addr_i(addr_o), .wdata_i(mem_wr_data_o),
        .rdata_o(mem_rd_data_i));
    initial forever #2.5 clock_i = ~clock_i;
    task automatic chk(logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    task automatic pulse(ref logic s);
        @(posedge clock_i) #1 s = 1;
        @(posedge clock_i) #1 s = 0;
    endtask
    // entry lands on the config word, one increment wraps to zero
    task automatic op(ref logic s, input logic [11:0] a, d);
        pulse(mode_entry_i);
        repeat (12'(a + 1)) pulse(addr_inc_i);
        prog_data_i = d;
        pulse(s);
    endtask
    task automatic rdc(logic [11:0] a, e);
        op(rd_req_i, a, 12'h000);
        chk({3'h0, rd_valid_o, rd_data_o}, {4'h1, e});
    endtask
    task automatic rst(int n);
        sys_rst_i = 1;
        repeat (n) @(posedge clock_i);
        #1 sys_rst_i = 0;
    endtask
    task automatic t_open();
        chk(config_word_o, CFG_ERASED);
        chk(osc_select_o, 16'h0001);
        for (int k = 0; k < 5; k++) begin
            op(prog_req_i, ad[k], {8'hA0, 4'(k)});
            rdc(ad[k], {8'hA0, 4'(k)});
        end
        clk_en_i = 0;
        pulse(addr_inc_i);
        chk(addr_o, 16'h0203);
        clk_en_i = 1;
        pulse(addr_inc_i);
        chk(addr_o, 16'h0000);
        $display("open done");
    endtask
    task automatic t_decode();
        for (int i = 0; i < 4; i++) begin
            rst(1);
            op(prog_req_i, CFG_ADDR, {7'h00, i[0], 1'b1, i[1], 2'(i)});
            @(posedge clock_i) #1;
            chk({reset_pin_enable_o, code_protect_o, watchdog_enable_o}, {i[0], 1'b0, i[1]});
            chk(osc_select_o, 4'h8 >> i);
        end
        $display("decode done");
    endtask
    task automatic t_prot();
        rst(1);
        op(prog_req_i, CFG_ADDR, 12'h017);
        for (int k = 0; k < 5; k++)
            rdc(ad[k], k == 2 ? 12'h000 : {8'hA0, 4'(k)});
        op(prog_req_i, 12'h040, 12'h555);
        chk({prog_blocked_o, mem_wr_o}, 16'h0002);
        op(prog_req_i, 12'h03F, 12'h5A5);
        chk({prog_blocked_o, mem_wr_o}, 16'h0001);
        rdc(12'h03F, 12'h5A5);
        rdc(CFG_ADDR, 12'h017);
        rdc(12'h000, 12'hA00);
        $display("protect done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst(6);
        t_open();
        t_decode();
        t_prot();
        end_sim();
    end
endmodule
